// [mpsc_params.svh]
/*
 * constants of the port status and command register pair: offsets, bit
 * positions, reset values and interrupt bits.
 * assumes inclusion by its bare name from the package and the module.
 */
`ifndef MPSC_PARAMS_SVH
`define MPSC_PARAMS_SVH

// ****************************************
// register offsets
// ****************************************
`define MPSC_ADDR_W 8
`define MPSC_OFF_STATUS 8'h01
`define MPSC_OFF_IRQ_STATUS 8'h08
`define MPSC_OFF_IRQ_MASK 8'h09

// ****************************************
// status bit positions and reset
// ****************************************
`define MPSC_BIT_RX_EMPTY 7
`define MPSC_BIT_TX_FULL 6
`define MPSC_BIT_RX_FIFO_FULL 5
`define MPSC_BIT_MODE 4
`define MPSC_BIT_OVERRUN 3
`define MPSC_BIT_TX_FIFO_NE 2
`define MPSC_STATUS_RESET 8'h80

// ****************************************
// interrupt bits: 0 command taken, 1 overrun
// ****************************************
`define MPSC_IRQ_W 2
`define MPSC_IRQ_CMD 0
`define MPSC_IRQ_OVR 1
`define MPSC_IRQ_RESET 2'h0

`endif

// [mpsc_pkg.sv]
/*
 * types shared by the port status and command registers.
 * assumes the params header sits in the same folder.
 */
`include "mpsc_params.svh"

package mpsc_pkg;

    // ****************************************
    // engine state carrier
    // ****************************************
    typedef struct packed {
        logic rx_empty;
        logic tx_full;
        logic rx_fifo_full;
        logic tx_fifo_not_empty;
        logic uart_mode;
        logic rx_fifo_enable;
        logic rx_byte_arrived;
    } mpsc_engine_type;

    typedef struct packed {
        logic [7:0] data;
        logic valid;
    } mpsc_command_type;

endpackage : mpsc_pkg

// [mpsc_regs.sv]
/*
 * status word and command port of the serial music port, with sticky
 * interrupt bits and mask.
 * assumes the engine signals come from logic on clk, so no synchroniser.
 *
 * the status word is not stored: it is assembled every cycle from the
 * engine levels, and only the overrun flag is a register of its own.
 * a read at offset 01h captures the word into rdata at the taking edge
 * and clears overrun in the same edge, unless a new overrun arrives then.
 * a write at offset 01h never touches status; it becomes a command byte
 * with a one-cycle valid pulse towards the engine.
 * interrupt status sits at 08h (write one to clear), the mask at 09h;
 * a mask bit at 1 lets the matching status bit reach irq.
 * limitation: the engine must hold rx_fifo_full for as long as the
 * receive side is full, since overrun is judged on that level alone.
 * limitation: rdata reads zero in every cycle that follows no read, so
 * a master that samples late sees zero rather than stale data.
 */
// Behaviour
// - status reads at 01h, writes go elsewhere
// - bit 7 shows receive side empty
// - bit 6 shows transmit side full
// - bit 5 receive fifo full, 0 unless uart mode or receive fifo on
// - bit 4 shows uart versus pass-through mode
// - byte into full receive side sets overrun
// - overrun in bit 3, cleared by read
// - bit 2 transmit fifo not empty, gated
// - reset status reads 80h
// - write to 01h is a command byte
// - transmit full reads 0 after reset
// - fifo flags live only in uart mode or with the receive fifo on
// - only overrun changes on status read
`timescale 1ns/1ps
`include "mpsc_params.svh"

module mpsc_regs (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // register port
    input wire logic [`MPSC_ADDR_W-1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_strobe,
    input wire logic rd_strobe,
    output logic [7:0] rdata,
    // engine side
    input wire mpsc_pkg::mpsc_engine_type engine,
    output mpsc_pkg::mpsc_command_type command,
    // interrupt
    output logic irq
);

    // ****************************************
    // address decode
    // ****************************************
    wire logic hit_status = addr == `MPSC_OFF_STATUS;
    wire logic hit_istat = addr == `MPSC_OFF_IRQ_STATUS;
    wire logic hit_imask = addr == `MPSC_OFF_IRQ_MASK;
    wire logic status_read = rd_strobe && hit_status;
    wire logic command_write = wr_strobe && hit_status;

    // ****************************************
    // status word assembly
    // ****************************************
    logic overrun_reg;
    logic overrun_next;
    logic [7:0] status_word;
    // fifo flags only count while the fifos are in use
    wire logic fifo_live = engine.uart_mode || engine.rx_fifo_enable;
    // a byte that lands while the receive side is full is lost and flagged
    wire logic overrun_event = engine.rx_byte_arrived && engine.rx_fifo_full;

    always_comb begin
        status_word = 8'h00;
        status_word[`MPSC_BIT_RX_EMPTY] = engine.rx_empty;
        status_word[`MPSC_BIT_TX_FULL] = engine.tx_full;
        status_word[`MPSC_BIT_RX_FIFO_FULL] = fifo_live && engine.rx_fifo_full;
        status_word[`MPSC_BIT_MODE] = engine.uart_mode;
        status_word[`MPSC_BIT_OVERRUN] = overrun_reg;
        status_word[`MPSC_BIT_TX_FIFO_NE] = fifo_live && engine.tx_fifo_not_empty;
    end

    // ****************************************
    // overrun flag
    // ****************************************
    // set beats the read clear so an arriving overrun is never lost
    assign overrun_next = overrun_event ? 1'b1 : (status_read ? 1'b0 : overrun_reg);

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            overrun_reg <= 1'b0;
        end else begin
            overrun_reg <= overrun_next;
        end
    end

    // ****************************************
    // interrupt status and mask
    // ****************************************
    logic [`MPSC_IRQ_W-1:0] istat_reg;
    logic [`MPSC_IRQ_W-1:0] imask_reg;
    logic [`MPSC_IRQ_W-1:0] istat_next;
    logic [`MPSC_IRQ_W-1:0] ievents;
    always_comb begin
        ievents = '0;
        ievents[`MPSC_IRQ_CMD] = command_write;
        ievents[`MPSC_IRQ_OVR] = overrun_event;
    end
    wire logic [`MPSC_IRQ_W-1:0] iclear = (wr_strobe && hit_istat) ? wdata[`MPSC_IRQ_W-1:0] : '0;
    assign istat_next = (istat_reg & ~iclear) | ievents;
    assign irq = |(istat_reg & imask_reg);

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            istat_reg <= `MPSC_IRQ_RESET;
            imask_reg <= `MPSC_IRQ_RESET;
        end else begin
            istat_reg <= istat_next;
            if (wr_strobe && hit_imask) imask_reg <= wdata[`MPSC_IRQ_W-1:0];
        end
    end

    // ****************************************
    // command output and read data
    // ****************************************
    logic [7:0] rdata_next;
    assign rdata_next = !rd_strobe ? 8'h00 :
                        hit_status ? status_word :
                        hit_istat ? {6'h00, istat_reg} :
                        hit_imask ? {6'h00, imask_reg} : 8'h00;

    // command byte held, valid is a one-cycle pulse
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            command <= '0;
            rdata <= 8'h00;
        end else begin
            command.valid <= command_write;
            if (command_write) command.data <= wdata;
            rdata <= rdata_next;
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    a_status_read_data: assert property (status_read |=> rdata == $past(status_word))
        else $error("status read data wrong");
    a_reserved_bits_zero: assert property (status_read |=> rdata[1:0] == 2'h0)
        else $error("reserved bits not zero");
    a_rx_empty_bit: assert property (status_read |=> rdata[7] == $past(engine.rx_empty))
        else $error("rx empty bit wrong");
    a_tx_full_bit: assert property (status_read |=> rdata[6] == $past(engine.tx_full))
        else $error("tx full bit wrong");
    a_fifo_full_gate: assert property (status_read && !fifo_live |=> rdata[5] == 1'b0)
        else $error("fifo full not gated");
    a_mode_bit: assert property (status_read |=> rdata[4] == $past(engine.uart_mode))
        else $error("mode bit wrong");
    a_overrun_sets: assert property (overrun_event |=> overrun_reg)
        else $error("overrun not set");
    a_overrun_clears: assert property (status_read && !overrun_event |=> !overrun_reg)
        else $error("overrun not cleared");
    a_txne_gate: assert property (status_read && !fifo_live |=> rdata[2] == 1'b0)
        else $error("tx fifo flag not gated");
    a_overrun_holds: assert property (!status_read && overrun_reg |=> overrun_reg)
        else $error("overrun dropped");
    a_cmd_pulse: assert property (command_write |=> command.valid && command.data == $past(wdata))
        else $error("command not passed");
    a_reset_status: assert property ($rose(reset_n) |-> !overrun_reg)
        else $error("overrun after reset");


    // ****************************************
    // read path assertions
    // ****************************************
    // a cycle with no read must leave the data lines quiet
    a_rdata_idle_zero: assert property (!rd_strobe |=> rdata == 8'h00)
        else $error("read data not zero when idle");

    // unmapped offsets answer zero
    a_unmapped_read_zero: assert property (rd_strobe && !hit_status && !hit_istat && !hit_imask
        |=> rdata == 8'h00)
        else $error("unmapped read not zero");

    // interrupt status readback
    a_istat_read_data: assert property (rd_strobe && hit_istat
        |=> rdata == {6'h00, $past(istat_reg)})
        else $error("irq status read wrong");

    // interrupt mask readback
    a_imask_read_data: assert property (rd_strobe && hit_imask
        |=> rdata == {6'h00, $past(imask_reg)})
        else $error("irq mask read wrong");

    // fifo full passes through while the fifos are in use
    a_fifo_full_live: assert property (status_read && fifo_live
        |=> rdata[5] == $past(engine.rx_fifo_full))
        else $error("fifo full bit wrong");

    // transmit fifo flag passes through while the fifos are in use
    a_txne_live: assert property (status_read && fifo_live
        |=> rdata[2] == $past(engine.tx_fifo_not_empty))
        else $error("tx fifo flag wrong");

    // overrun shows its value before the read clears it
    a_overrun_bit: assert property (status_read |=> rdata[3] == $past(overrun_reg))
        else $error("overrun bit wrong");

    // ****************************************
    // overrun flag assertions
    // ****************************************
    // a write to the status offset must not disturb the flag
    a_write_keeps_overrun: assert property (wr_strobe && !rd_strobe && !overrun_event
        |=> overrun_reg == $past(overrun_reg))
        else $error("write changed overrun");

    // only a real overrun may raise the flag
    a_overrun_no_spurious: assert property (!overrun_event && !overrun_reg
        |=> !overrun_reg)
        else $error("overrun set without event");

    // ****************************************
    // interrupt assertions
    // ****************************************
    // command write raises its sticky bit
    a_irq_cmd_event: assert property (command_write |=> istat_reg[`MPSC_IRQ_CMD])
        else $error("command irq bit not set");

    // overrun raises its sticky bit
    a_irq_ovr_event: assert property (overrun_event |=> istat_reg[`MPSC_IRQ_OVR])
        else $error("overrun irq bit not set");

    // a fully masked bank never interrupts
    a_irq_masked: assert property (imask_reg == 2'h0 |-> !irq)
        else $error("irq with all masked");

    // the command sticky bit survives until a write to interrupt status
    a_istat_sticky: assert property (istat_reg[`MPSC_IRQ_CMD] && !(wr_strobe && hit_istat)
        |=> istat_reg[`MPSC_IRQ_CMD])
        else $error("command irq bit dropped");

    // writing one clears the command bit
    a_istat_clear_cmd: assert property (wr_strobe && hit_istat && wdata[0]
        |=> !istat_reg[`MPSC_IRQ_CMD])
        else $error("command irq bit not cleared");

    // writing one clears the overrun bit unless a new overrun lands
    a_istat_clear_ovr: assert property (wr_strobe && hit_istat && wdata[1] && !overrun_event
        |=> !istat_reg[`MPSC_IRQ_OVR])
        else $error("overrun irq bit not cleared");

    // writing zero leaves the overrun bit alone
    a_istat_zero_keeps: assert property (wr_strobe && hit_istat && !wdata[1] && !overrun_event
        |=> istat_reg[`MPSC_IRQ_OVR] == $past(istat_reg[`MPSC_IRQ_OVR]))
        else $error("irq bit changed by zero write");

    // mask takes the written value
    a_imask_write: assert property (wr_strobe && hit_imask
        |=> imask_reg == $past(wdata[1:0]))
        else $error("mask write lost");

    // mask holds between writes
    a_imask_holds: assert property (!(wr_strobe && hit_imask) |=> $stable(imask_reg))
        else $error("mask changed without write");

    // ****************************************
    // command port assertions
    // ****************************************
    // valid lasts exactly the cycle after the write
    a_cmd_valid_clear: assert property (!command_write |=> !command.valid)
        else $error("command valid too long");

    // command byte holds between writes
    a_cmd_data_holds: assert property (!command_write |=> $stable(command.data))
        else $error("command byte changed");

    // ****************************************
    // reset assertions
    // ****************************************
    // read data quiet at the first edge out of reset
    a_reset_rdata: assert property ($rose(reset_n) |-> rdata == 8'h00)
        else $error("read data after reset");

    // interrupt bank starts empty and masked
    a_reset_irq: assert property ($rose(reset_n) |-> !irq && istat_reg == 2'h0
        && imask_reg == 2'h0)
        else $error("irq state after reset");

    // no command pending out of reset
    a_reset_command: assert property ($rose(reset_n) |-> !command.valid)
        else $error("command valid after reset");

    // ****************************************
    // covers of the main scenarios
    // ****************************************
    c_command: cover property (command_write ##1 command.valid);
    c_overrun_read: cover property (overrun_event ##1 status_read ##1 !overrun_reg);
    c_irq: cover property (irq);
    // reading status with the fifos off exercises the gating
    c_fifo_gated_read: cover property (status_read && !fifo_live && engine.rx_fifo_full);
    // interrupt dropped by a one write
    c_irq_cleared: cover property (irq ##1 (wr_strobe && hit_istat) ##1 !irq);

endmodule : mpsc_regs

// [test_midi_port_status_command_regs.sv]
/*
 * self-checking bench for the port status word, command port and interrupt bits.
 * assumes mpsc_pkg and mpsc_regs are compiled first; interrupt mask 1 passes a bit.
 */
`timescale 1ns/1ps

module test_midi_port_status_command_regs;
    // ****************************************
    // stimulus and dut
    // ****************************************
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr_strobe = 1'b0;
    logic rd_strobe = 1'b0;
    logic [7:0] rdata;
    logic irq;
    mpsc_pkg::mpsc_engine_type engine = 7'h40; // receive side empty
    mpsc_pkg::mpsc_command_type command;
    int mismatches = 0;
    int tests_run = 0;

    mpsc_regs DUT (.clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata),
        .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rdata(rdata),
        .engine(engine), .command(command), .irq(irq));

    // free-running 20 mhz clock
    initial begin
        forever #25 clk = ~clk;
    end

    // ****************************************
    // shared tasks
    // ****************************************
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : chk

    // one-cycle write; returns just after the taking edge
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_strobe <= 1'b1;
        @(posedge clk);
        wr_strobe <= 1'b0;
        #1;
    endtask : wr

    // data only stands in the cycle after the strobe, so sample there
    task rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd_strobe <= 1'b1;
        @(posedge clk);
        rd_strobe <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask : rd

    // ****************************************
    // scenarios
    // ****************************************
    task t_reset;
        rd(8'h01, 8'h80);
        rd(8'h03, 8'h00);
    endtask : t_reset

    // fifo flags pass only in uart mode or with the receive fifo on
    task t_flags;
        engine <= 7'h3c;
        rd(8'h01, 8'h74);
        rd(8'h01, 8'h74);
        engine <= 7'h78;
        rd(8'h01, 8'hc0);
        engine <= 7'h7a;
        rd(8'h01, 8'he4);
    endtask : t_flags

    // byte lands on a full receive side, then one read clears it
    task t_overrun;
        @(posedge clk);
        engine <= 7'h3d;
        @(posedge clk);
        engine <= 7'h3c;
        rd(8'h01, 8'h7c);
        rd(8'h01, 8'h74);
        rd(8'h08, 8'h02);
        chk({7'h00, irq}, 8'h00);
        wr(8'h09, 8'h03);
        chk({7'h00, irq}, 8'h01);
        wr(8'h08, 8'h02);
        chk({7'h00, irq}, 8'h00);
    endtask : t_overrun

    task t_cmd;
        wr(8'h01, 8'h5a);
        chk({7'h00, command.valid}, 8'h01);
        chk(command.data, 8'h5a);
        chk({7'h00, irq}, 8'h01);
        @(posedge clk);
        #1;
        chk({7'h00, command.valid}, 8'h00);
        rd(8'h01, 8'h74);
        wr(8'h09, 8'h00);
        chk({7'h00, irq}, 8'h00);
        wr(8'h09, 8'h03);
        chk({7'h00, irq}, 8'h01);
        wr(8'h08, 8'h01);
        chk({7'h00, irq}, 8'h00);
        rd(8'h08, 8'h00);
        rd(8'h09, 8'h03);
    endtask : t_cmd

    // ****************************************
    // verdict, watchdog, main sequence
    // ****************************************
    task finish_test;
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : finish_test

    // the run needs about 43 cycles; this allows many times that
    initial begin
        #200000;
        mismatches++;
        finish_test;
    end

    initial begin
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        t_reset;
        t_flags;
        t_overrun;
        t_cmd;
        finish_test;
    end
endmodule : test_midi_port_status_command_regs
